// File: tcr_pkg.sv
// Package: register map, reset values, ranges and timing for the transmit control and redundancy block
package tcr_pkg;
   localparam logic [7:0] A_IDENT = 8'h00;
   localparam logic [7:0] A_MONFREQ = 8'h04;
   localparam logic [7:0] A_LOOP = 8'h08;
   localparam logic [7:0] A_TRIM = 8'h0C;
   localparam logic [7:0] A_PMODE = 8'h10;
   localparam logic [7:0] A_BTHR = 8'h14;
   localparam logic [7:0] A_PWR = 8'h18;
   localparam logic [7:0] A_ATTEN = 8'h1C;
   localparam logic [7:0] A_DELAY = 8'h20;
   localparam logic [7:0] A_PUST = 8'h24;
   localparam logic [7:0] A_OUTEN = 8'h28;
   localparam logic [7:0] A_OTEN = 8'h2C;
   localparam logic [7:0] A_HOURS = 8'h30;
   localparam logic [7:0] A_RCFG = 8'h34;
   localparam logic [7:0] A_REVM = 8'h38;
   localparam logic [7:0] A_PORT = 8'h3C;
   localparam logic [7:0] A_WARM = 8'h40;
   localparam logic [7:0] A_STYPE = 8'h44;
   localparam logic [7:0] A_ONLINE = 8'h48;
   localparam logic [7:0] A_ERR = 8'h4C;
   localparam logic [1:0] LOOP_MAX = 2'h2;
   localparam logic signed [7:0] TRIM_MIN = -8'sd80;
   localparam logic signed [7:0] TRIM_MAX = 8'sd80;
   localparam logic [7:0] ATTEN_MAX = 8'hA0;
   localparam logic [8:0] DELAY_MAX = 9'h1F4;
   localparam logic signed [7:0] OT_LIMIT = 8'sd85;
   localparam logic signed [11:0] PWR_SPAN = 12'sd200;
   localparam logic signed [11:0] RATED_PWR_DEF = 12'sd400;
   localparam logic signed [11:0] BTHR_DEF = 12'sd200;
   localparam logic [15:0] MONFREQ_DEF = 16'h1800;
   localparam logic [15:0] IF_TO_RF_MHZ = 16'h1700;
   localparam int MONFREQ_IF_BIT = 31;
   localparam logic [1:0] ST_DISABLED = 2'h0;
   localparam logic [1:0] ST_ON = 2'h1;
   localparam logic [1:0] ST_MUTED = 2'h2;
   localparam longint SECOND_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 10;
   localparam int CYC_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam int SEC_PER_HOUR = 3600;
   typedef enum logic {TCR_BUS_IDLE, TCR_BUS_WAIT} tcr_bus_t;
endpackage : tcr_pkg

// File: tcr_tick.sv
// Modulo counter that advances while en is high and emits a one-cycle tick enable
`timescale 1ns/1ps
`default_nettype none
module tcr_tick #(
   parameter int MOD = 100
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic en,
   output logic tick
);
   logic [31:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (en) begin
            if (cnt_r >= 32'(MOD - 1)) begin
               cnt_r <= 32'h0000_0000;
               tick <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 32'h0000_0001;
            end
         end
      end
   end
endmodule : tcr_tick
`default_nettype wire

// File: tcr_top.sv
// Transmit control and 1+1 redundancy registers behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module tcr_top import tcr_pkg::*; #(
   parameter int TICKS_PER_SEC = CYC_PER_SEC,
   parameter int SECS_PER_HOUR = SEC_PER_HOUR
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [4:0] band_code_pin,
   input wire logic spectral_inv_pin,
   input wire logic red_enabled_pin,
   input wire logic red_master_pin,
   input wire logic red_clone_pin,
   input wire logic a_fault_pin,
   input wire logic b_fault_pin,
   input wire logic tx_fault_pin,
   input wire logic [7:0] temperature_pin,
   input wire logic signed [11:0] power_sample,
   input wire logic power_sample_valid,
   output logic tx_enable,
   output logic tx_mute,
   output logic overtemp_alarm,
   output logic wg_switch_b,
   output logic [1:0] loop_mode,
   output logic signed [7:0] gain_trim,
   output logic gain_zero,
   output logic [7:0] attenuator,
   output logic [15:0] monitor_freq_rf
);
   localparam int SYN_W = 20;

   logic [SYN_W-1:0] syn1_r, syn2_r;
   logic [4:0] band_s;
   logic inv_s, red_en_s, master_s, clone_s, a_flt_s, b_flt_s, tx_flt_s;
   logic signed [7:0] temp_s;
   tcr_bus_t bus_st_r;
   logic [7:0] addr_r;
   logic wr_r, accept, do_wr, do_rd, wr_bad;
   logic [31:0] rd_val;
   logic pmode_r, pust_r, outen_r, oten_r, revm_r, port_r, warm_r, stype_r, online_r, nrv_hold_r, err_r;
   logic signed [11:0] bthr_r, pwr_r;
   logic [8:0] delay_r, secs_r;
   logic [31:0] hours_r;
   logic delay_done, delay_done_r, sec_tick, hour_tick, mute, transmitting, is_online;
   logic sw_cmd;

   // Pins pass two flops; only the second stage is read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         syn1_r <= '0;
         syn2_r <= '0;
      end else begin
         syn1_r <= {temperature_pin, tx_fault_pin, b_fault_pin, a_fault_pin, red_clone_pin,
                    red_master_pin, red_enabled_pin, spectral_inv_pin, band_code_pin};
         syn2_r <= syn1_r;
      end
   end
   assign {temp_s, tx_flt_s, b_flt_s, a_flt_s, clone_s, master_s, red_en_s, inv_s, band_s} = syn2_r;

   // One wait state per transfer so read data always comes from a flop
   assign accept = hsel && htrans[1] && hready;
   assign do_wr = (bus_st_r == TCR_BUS_WAIT) && wr_r;
   assign do_rd = (bus_st_r == TCR_BUS_WAIT) && !wr_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_r <= TCR_BUS_IDLE;
         hreadyout <= 1'b1;
         addr_r <= 8'h00;
         wr_r <= 1'b0;
      end else begin
         unique case (bus_st_r)
            TCR_BUS_IDLE: begin
               if (accept) begin
                  bus_st_r <= TCR_BUS_WAIT;
                  hreadyout <= 1'b0;
                  addr_r <= {haddr[7:2], 2'b00};
                  wr_r <= hwrite;
               end
            end
            TCR_BUS_WAIT: begin
               bus_st_r <= TCR_BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   assign is_online = (online_r == port_r);

   // Range and access check of a write
   always_comb begin
      wr_bad = 1'b0;
      unique case (addr_r)
         A_IDENT, A_PWR, A_HOURS, A_RCFG: wr_bad = 1'b1;
         A_LOOP: wr_bad = (hwdata[31:2] != 30'h0) || (hwdata[1:0] > LOOP_MAX);
         A_TRIM: wr_bad = (signed'(hwdata) < 32'(TRIM_MIN)) || (signed'(hwdata) > 32'(TRIM_MAX));
         A_ATTEN: wr_bad = hwdata > 32'(ATTEN_MAX);
         A_DELAY: wr_bad = hwdata > 32'(DELAY_MAX);
         A_BTHR: wr_bad = (signed'(hwdata) > 32'(RATED_PWR_DEF)) ||
                          (signed'(hwdata) < 32'(RATED_PWR_DEF - PWR_SPAN));
         A_PMODE, A_PUST, A_OUTEN, A_OTEN, A_PORT, A_WARM, A_STYPE, A_ONLINE:
            wr_bad = hwdata[31:1] != 31'h0;
         A_REVM: wr_bad = (hwdata[31:1] != 31'h0) || !(is_online && master_s);
         A_MONFREQ: wr_bad = hwdata[30:16] != 15'h0;
         default: wr_bad = 1'b0;
      endcase
   end

   // Loop, trim, attenuator and monitor settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loop_mode <= 2'h0;
         gain_trim <= 8'sh00;
         gain_zero <= 1'b0;
         attenuator <= 8'h00;
         monitor_freq_rf <= MONFREQ_DEF;
         pmode_r <= 1'b0;
         bthr_r <= BTHR_DEF;
      end else begin
         gain_zero <= 1'b0;
         if (do_wr && !wr_bad) begin
            unique case (addr_r)
               A_LOOP: loop_mode <= hwdata[1:0];
               A_TRIM: begin
                  gain_trim <= hwdata[7:0];
                  gain_zero <= (hwdata[7:0] == 8'h00);
               end
               A_ATTEN: attenuator <= hwdata[7:0];
               A_MONFREQ: monitor_freq_rf <= hwdata[MONFREQ_IF_BIT] ?
                                             hwdata[15:0] + IF_TO_RF_MHZ : hwdata[15:0];
               A_PMODE: pmode_r <= hwdata[0];
               A_BTHR: bthr_r <= hwdata[11:0];
               default: ;
            endcase
         end
      end
   end

   // Power reading: continuous follows every sample, burst keeps only valid bursts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_r <= RATED_PWR_DEF - PWR_SPAN;
      end else if (power_sample_valid && (!pmode_r || power_sample >= bthr_r)) begin
         if (power_sample > RATED_PWR_DEF) begin
            pwr_r <= RATED_PWR_DEF;
         end else if (power_sample < RATED_PWR_DEF - PWR_SPAN) begin
            pwr_r <= RATED_PWR_DEF - PWR_SPAN;
         end else begin
            pwr_r <= power_sample;
         end
      end
   end

   // Output control settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         delay_r <= 9'h000;
         pust_r <= 1'b1;
         outen_r <= 1'b1;
         oten_r <= 1'b1;
      end else begin
         if (delay_done && !delay_done_r) begin
            outen_r <= pust_r;
         end else if (do_wr && !wr_bad && addr_r == A_OUTEN) begin
            outen_r <= hwdata[0];
         end
         if (do_wr && !wr_bad) begin
            unique case (addr_r)
               A_DELAY: delay_r <= hwdata[8:0];
               A_PUST: pust_r <= hwdata[0];
               A_OTEN: oten_r <= hwdata[0];
               default: ;
            endcase
         end
      end
   end

   tcr_tick #(.MOD(TICKS_PER_SEC)) u_sec (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(1'b1),
      .tick(sec_tick)
   );

   // Hours advance only while transmitting; partial hours are kept across mute
   tcr_tick #(.MOD(SECS_PER_HOUR)) u_hour (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(sec_tick && transmitting),
      .tick(hour_tick)
   );

   // Power-up delay; the counter saturates so it never wraps back into mute
   assign delay_done = secs_r >= delay_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         secs_r <= 9'h000;
         delay_done_r <= 1'b0;
      end else begin
         delay_done_r <= delay_done;
         if (sec_tick && secs_r != DELAY_MAX) begin
            secs_r <= secs_r + 9'h001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overtemp_alarm <= 1'b0;
      end else begin
         overtemp_alarm <= oten_r && (temp_s >= OT_LIMIT);
      end
   end

   assign mute = !delay_done || overtemp_alarm || tx_flt_s ||
                 (warm_r && port_r && !online_r && red_en_s);
   assign transmitting = tx_enable;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_enable <= 1'b0;
         tx_mute <= 1'b1;
         hours_r <= 32'h0000_0000;
      end else begin
         tx_enable <= outen_r && !mute;
         tx_mute <= mute;
         if (hour_tick) begin
            hours_r <= hours_r + 32'h0000_0001;
         end
      end
   end

   // Redundancy settings and switch control
   assign sw_cmd = do_wr && !wr_bad && addr_r == A_ONLINE;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         revm_r <= 1'b0;
         port_r <= 1'b0;
         warm_r <= 1'b0;
         stype_r <= 1'b1;
      end else if (do_wr && !wr_bad) begin
         unique case (addr_r)
            A_REVM: revm_r <= hwdata[0];
            A_PORT: port_r <= hwdata[0];
            A_WARM: warm_r <= hwdata[0];
            A_STYPE: stype_r <= hwdata[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         online_r <= 1'b0;
         nrv_hold_r <= 1'b0;
      end else if (sw_cmd) begin
         online_r <= hwdata[0];
         nrv_hold_r <= 1'b0;
      end else if (stype_r && red_en_s) begin
         if (!online_r && a_flt_s && !b_flt_s && !nrv_hold_r) begin
            online_r <= 1'b1;
            nrv_hold_r <= revm_r;
         end else if (online_r && b_flt_s && !a_flt_s && !revm_r) begin
            online_r <= 1'b0;
         end
      end
   end
   assign wg_switch_b = online_r;

   // Refused writes set a sticky flag; reading it clears, a new refusal wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_r <= 1'b0;
      end else if (do_wr && wr_bad) begin
         err_r <= 1'b1;
      end else if (do_rd && addr_r == A_ERR) begin
         err_r <= 1'b0;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (addr_r)
         A_IDENT: rd_val = {26'h0, inv_s, band_s};
         A_MONFREQ: rd_val = {16'h0000, monitor_freq_rf};
         A_LOOP: rd_val = {30'h0, loop_mode};
         A_TRIM: rd_val = 32'(gain_trim);
         A_PMODE: rd_val = {31'h0, pmode_r};
         A_BTHR: rd_val = 32'(bthr_r);
         A_PWR: rd_val = 32'(pwr_r);
         A_ATTEN: rd_val = {24'h0, attenuator};
         A_DELAY: rd_val = {23'h0, delay_r};
         A_PUST: rd_val = {31'h0, pust_r};
         A_OUTEN: rd_val = {30'h0, !outen_r ? ST_DISABLED : (tx_mute ? ST_MUTED : ST_ON)};
         A_OTEN: rd_val = {30'h0, overtemp_alarm, oten_r};
         A_HOURS: rd_val = hours_r;
         A_RCFG: rd_val = {29'h0, clone_s, master_s, red_en_s};
         A_REVM: rd_val = {31'h0, revm_r};
         A_PORT: rd_val = {31'h0, port_r};
         A_WARM: rd_val = {31'h0, warm_r};
         A_STYPE: rd_val = {31'h0, stype_r};
         A_ONLINE: rd_val = {31'h0, online_r};
         A_ERR: rd_val = {31'h0, err_r};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (do_rd) begin
         hrdata <= rd_val;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_wait_state;
      accept && bus_st_r == TCR_BUS_IDLE |=> !hreadyout ##1 hreadyout;
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("transfer not answered after one wait");

   property p_loop_range;
      loop_mode <= LOOP_MAX;
   endproperty
   a_loop_range: assert property (p_loop_range) else $error("loop mode out of range");

   property p_trim_range;
      gain_trim >= TRIM_MIN && gain_trim <= TRIM_MAX;
   endproperty
   a_trim_range: assert property (p_trim_range) else $error("gain trim out of range");

   property p_atten_range;
      attenuator <= ATTEN_MAX && delay_r <= DELAY_MAX;
   endproperty
   a_atten_range: assert property (p_atten_range) else $error("setting out of range");

   property p_delay_mute;
      !delay_done |=> !tx_enable && tx_mute;
   endproperty
   a_delay_mute: assert property (p_delay_mute) else $error("output live during power-up delay");

   property p_fault_off;
      tx_flt_s |=> !tx_enable;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("output enabled under fault");

   property p_overtemp;
      oten_r && temp_s >= OT_LIMIT |=> overtemp_alarm ##1 !tx_enable;
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("over-temperature not muted");

   property p_both_faulted;
      a_flt_s && b_flt_s && !sw_cmd |=> $stable(online_r);
   endproperty
   a_both_faulted: assert property (p_both_faulted) else $error("switch with both sides faulted");

   property p_manual;
      !stype_r && !sw_cmd |=> $stable(online_r);
   endproperty
   a_manual: assert property (p_manual) else $error("manual mode switched without command");

   property p_refused;
      do_wr && wr_bad |=> err_r && $stable(loop_mode) && $stable(revm_r);
   endproperty
   a_refused: assert property (p_refused) else $error("refused write changed state");
endmodule : tcr_top
`default_nettype wire

// File: tcr_host.sv
// Host model: AHB-Lite master that issues single word transfers
`timescale 1ns/1ps
`default_nettype none
module tcr_host (
   input wire logic hclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Entered just after a rising edge; waits are open, only the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : ~d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : tcr_host
`default_nettype wire

// File: tcr_top_tb.sv
// Self-checking bench for the transmit control and redundancy block
`timescale 1ns/1ps
`default_nettype none
module tcr_top_tb import tcr_pkg::*; ;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, inv, r_en, r_ms, r_cl, a_f, b_f, t_f, psv;
   logic tx_enable, tx_mute, overtemp_alarm, wg, gain_zero;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, loop_mode;
   logic [2:0] hsize;
   logic [4:0] band;
   logic [7:0] temp, attenuator;
   logic signed [7:0] gain_trim;
   logic signed [11:0] ps;
   logic [15:0] mfreq;
   int mismatches, n_checks, cyc, zeros;
   logic [7:0] ba [10] = '{A_IDENT, A_PWR, A_HOURS, A_RCFG, A_LOOP, A_TRIM, A_TRIM, A_ATTEN, A_DELAY, A_BTHR};
   logic [31:0] bv [10] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h3, 32'hFFFFFFAF, 32'h51, 32'hA1, 32'h1F5, 32'hC7};
   logic [7:0] da [14] = '{A_LOOP, A_TRIM, A_PMODE, A_BTHR, A_ATTEN, A_DELAY, A_PUST, A_OUTEN, A_OTEN, A_REVM,
      A_PORT, A_WARM, A_STYPE, A_ONLINE};
   logic [31:0] dv [14] = '{32'h0, 32'h0, 32'h0, 32'hC8, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0,
      32'h1, 32'h0};

   tcr_host i_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // Short second and hour keep the delay and hour counts inside the run
   tcr_top #(.TICKS_PER_SEC(10), .SECS_PER_HOUR(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .band_code_pin(band), .spectral_inv_pin(inv),
      .red_enabled_pin(r_en), .red_master_pin(r_ms), .red_clone_pin(r_cl), .a_fault_pin(a_f), .b_fault_pin(b_f),
      .tx_fault_pin(t_f), .temperature_pin(temp), .power_sample(ps), .power_sample_valid(psv),
      .tx_enable(tx_enable), .tx_mute(tx_mute), .overtemp_alarm(overtemp_alarm), .wg_switch_b(wg),
      .loop_mode(loop_mode), .gain_trim(gain_trim), .gain_zero(gain_zero), .attenuator(attenuator),
      .monitor_freq_rf(mfreq));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (gain_zero === 1'b1) zeros++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic w(input int n);
      repeat (n) @(posedge hclk);
   endtask : w
   // Reading the error flag also clears it, so each refusal is judged alone
   task automatic we(input logic [7:0] a, input logic [31:0] d, input logic e);
      wr(a, d);
      rd(A_ERR);
      chk({31'h0, q[0]}, {31'h0, e});
   endtask : we
   task automatic defaults();
      for (int i = 0; i < 14; i++) begin
         rd(da[i]);
         chk(q, dv[i]);
      end
   endtask : defaults
   task automatic psend(input logic signed [11:0] v);
      ps <= v;
      psv <= 1'b1;
      @(posedge hclk);
      psv <= 1'b0;
      @(posedge hclk);
   endtask : psend
   function automatic logic [11:0] pclamp(input logic signed [11:0] v);
      if (v > RATED_PWR_DEF) return RATED_PWR_DEF;
      if (v < RATED_PWR_DEF - PWR_SPAN) return RATED_PWR_DEF - PWR_SPAN;
      return v;
   endfunction : pclamp

   initial begin
      logic [31:0] h;
      logic signed [11:0] v, last;
      logic [15:0] f;
      int t;
      hresetn = 1'b0;
      {inv, r_en, r_ms, r_cl, a_f, b_f, t_f, psv} = 8'h0;
      band = 5'h3;
      temp = 8'h19;
      ps = 12'h0;
      void'($urandom(32'h74B6));
      w(20);
      hresetn <= 1'b1;
      w(2);
      chk(wg, 1'b0);
      chk(mfreq, MONFREQ_DEF);
      defaults();
      band <= 5'($urandom_range(21, 3));
      inv <= 1'($urandom);
      w(4);
      rd(A_IDENT);
      chk(q, {26'h0, inv, band});
      for (int i = 0; i < 10; i++) we(ba[i], bv[i], 1'b1);
      chk(hresp, 1'b0);
      we(8'h80, 32'h5, 1'b0);
      rd(8'h80);
      chk(q, 32'h0);
      defaults();
      for (int i = 0; i < 8; i++) begin
         t = (i == 0) ? -80 : (i == 1) ? 80 : int'($urandom_range(160)) - 80;
         f = (i == 0) ? 16'hA0 : 16'($urandom_range(160));
         h = 32'($urandom_range(2));
         wr(A_ATTEN, {16'h0, f});
         wr(A_LOOP, h);
         wr(A_TRIM, 32'(t));
         w(3);
         chk({24'h0, attenuator}, {16'h0, f});
         chk({24'h0, gain_trim}, {24'h0, 8'(t)});
         rd(A_LOOP);
         chk({30'h0, loop_mode}, h);
         chk(q, h);
      end
      t = zeros;
      wr(A_TRIM, 32'h0);
      w(3);
      chk(32'(zeros - t), 32'h1);
      f = 16'($urandom_range(16'h800, 16'h100));
      wr(A_MONFREQ, {16'h8000, f});
      w(3);
      chk(mfreq, f + IF_TO_RF_MHZ);
      wr(A_MONFREQ, {16'h0, f + 16'h2000});
      w(3);
      chk(mfreq, f + 16'h2000);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            wr(A_BTHR, 32'h12C);
            wr(A_PMODE, 32'h1);
         end
         v = (i == 0) ? 12'sh1C2 : (i == 1) ? 12'sh096 : (i == 5) ? 12'sh0FA : 12'($urandom_range(400, 200));
         psend(v);
         if (i < 4 || v >= 12'sh12C) last = pclamp(v);
         rd(A_PWR);
         chk({20'h0, q[11:0]}, {20'h0, last});
      end
      temp <= 8'h54;
      w(8);
      chk({overtemp_alarm, tx_enable}, 2'h1);
      temp <= 8'h55;
      w(8);
      chk({overtemp_alarm, tx_mute, tx_enable}, 3'h6);
      rd(A_OUTEN);
      chk(q, 32'h2);
      rd(A_OTEN);
      chk(q, 32'h3);
      wr(A_OTEN, 32'h0);
      temp <= 8'h64;
      w(8);
      chk({overtemp_alarm, tx_enable}, 2'h1);
      wr(A_OTEN, 32'h1);
      temp <= 8'h19;
      t_f <= 1'b1;
      w(8);
      chk({tx_mute, tx_enable}, 2'h2);
      rd(A_HOURS);
      h = q;
      w(400);
      rd(A_HOURS);
      chk(q, h);
      t_f <= 1'b0;
      w(8);
      chk(tx_enable, 1'b1);
      rd(A_HOURS);
      h = q;
      w(400);
      rd(A_HOURS);
      chk(32'((q - h >= 9) && (q - h <= 11)), 32'h1);
      wr(A_OUTEN, 32'h0);
      w(3);
      chk(tx_enable, 1'b0);
      rd(A_OUTEN);
      chk(q, 32'h0);
      wr(A_OUTEN, 32'h1);
      {r_en, r_ms, r_cl} <= 3'($urandom);
      w(6);
      rd(A_RCFG);
      chk(q, {29'h0, r_cl, r_ms, r_en});
      {r_en, r_ms} <= 2'h3;
      wr(A_PORT, 32'h1);
      wr(A_WARM, 32'h1);
      w(6);
      chk({wg, tx_mute, tx_enable}, 3'h2);
      we(A_REVM, 32'h1, 1'b1);
      wr(A_PORT, 32'h0);
      wr(A_WARM, 32'h0);
      a_f <= 1'b1;
      w(8);
      chk({wg, tx_mute}, 2'h2);
      rd(A_ONLINE);
      chk(q, 32'h1);
      b_f <= 1'b1;
      w(8);
      chk(wg, 1'b1);
      a_f <= 1'b0;
      w(8);
      chk(wg, 1'b0);
      b_f <= 1'b0;
      r_ms <= 1'b0;
      w(6);
      we(A_REVM, 32'h1, 1'b1);
      r_ms <= 1'b1;
      w(6);
      we(A_REVM, 32'h1, 1'b0);
      a_f <= 1'b1;
      w(8);
      chk(wg, 1'b1);
      {a_f, b_f} <= 2'h1;
      w(8);
      chk(wg, 1'b1);
      b_f <= 1'b0;
      wr(A_ONLINE, 32'h0);
      w(4);
      chk(wg, 1'b0);
      wr(A_STYPE, 32'h0);
      a_f <= 1'b1;
      w(8);
      chk(wg, 1'b0);
      wr(A_ONLINE, 32'h1);
      w(4);
      chk(wg, 1'b1);
      a_f <= 1'b0;
      hresetn <= 1'b0;
      w(2);
      hresetn <= 1'b1;
      w(1);
      wr(A_PUST, 32'h0);
      wr(A_DELAY, 32'h1F4);
      w(4);
      chk({tx_mute, tx_enable}, 2'h2);
      rd(A_OUTEN);
      chk(q, 32'h2);
      w(5100);
      chk({tx_mute, tx_enable}, 2'h0);
      wr(A_OUTEN, 32'h1);
      w(3);
      chk(tx_enable, 1'b1);
      final_report();
   end
endmodule : tcr_top_tb
`default_nettype wire
